/* File: src/dfw_top.sv */
// line bank with glitch filter, change detection, power-up states and output watchdog
// assumes host software on a plain register port; pins are resolved by the pad ring
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module dfw_top #(
    parameter bit ALT_VARIANT = 1'b0,
    parameter int PWRUP_CYCLES = dfw_pkg::PWRUP_CYC,
    parameter int PWRUP_CYCLES_ALT = dfw_pkg::PWRUP_ALT_CYC,
    parameter int FILT_HALF_LIMIT = dfw_pkg::FILT_HALF_MAX,
    parameter int ALT_HALF_LONG = dfw_pkg::ALT_HALF_SLOW
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // register port
    input wire dfw_pkg::dfw_bus_req_s bus_i,
    output logic [dfw_pkg::DATA_W-1:0] rdata_o,
    // lines
    input wire logic [dfw_pkg::NUM_LINES-1:0] pin_i,
    output logic [dfw_pkg::NUM_LINES-1:0] pin_o,
    output logic [dfw_pkg::NUM_LINES-1:0] pin_oe_o,
    // stored power-up configuration
    input wire logic [dfw_pkg::NUM_LINES-1:0] pwrup_dir_i,
    input wire logic [dfw_pkg::NUM_LINES-1:0] pwrup_val_i,
    // events
    output logic change_irq_o,
    output logic wd_expired_o
);
    import dfw_pkg::*;

    localparam logic [31:0] PU_LAST = 32'(ALT_VARIANT ? PWRUP_CYCLES_ALT - 1 : PWRUP_CYCLES - 1);
    localparam logic [7:0] WD_TICK_LAST =
        8'(ALT_VARIANT ? WD_TICK_ALT_CYC - 1 : WD_TICK_CYC - 1);
    localparam logic [31:0] HALF_MIN = 32'(FILT_HALF_MIN);
    localparam logic [31:0] HALF_MAX = 32'(FILT_HALF_LIMIT);
    localparam logic [31:0] HALF_FAST = 32'(ALT_HALF_FAST);
    localparam logic [31:0] HALF_MID = 32'(ALT_HALF_MID);
    localparam logic [31:0] HALF_LONG = 32'(ALT_HALF_LONG);
    localparam logic [1:0] SEL_FAST = 2'h0;
    localparam logic [1:0] SEL_MID = 2'h1;

    typedef struct packed {
        // software-visible configuration
        logic [NUM_LINES-1:0] dir;
        logic [NUM_LINES-1:0] out;
        logic [NUM_LINES-1:0] filt_en;
        logic [NUM_LINES-1:0] rise_en;
        logic [NUM_LINES-1:0] fall_en;
        logic [NUM_LINES-1:0] safe_en;
        logic [NUM_LINES-1:0] safe_val;
        logic [DATA_W-1:0] fdiv;
        logic [DATA_W-1:0] wd_timeout;
        // filter clock
        logic [DATA_W-1:0] fcnt;
        logic ftick;
        // change detection
        logic [NUM_LINES-1:0] prev_level;
        logic chg;
        logic ovf;
        logic cd_seen;
        // watchdog
        logic armed;
        logic expired;
        logic safe_hold;
        logic [DATA_W-1:0] wd_cnt;
        logic [7:0] wd_tcnt;
        // power-up
        logic [31:0] pu_cnt;
        logic pu_done;
        // registered outputs
        logic [DATA_W-1:0] rdata;
        logic [NUM_LINES-1:0] pin;
        logic [NUM_LINES-1:0] pin_oe;
    } dfw_state_s;

    dfw_state_s q;
    dfw_state_s next_q;

    logic [NUM_LINES-1:0] level;
    logic [NUM_LINES-1:0] rise;
    logic [NUM_LINES-1:0] fall;
    logic [NUM_LINES-1:0] read_mask;
    logic [NUM_LINES-1:0] force_mask;
    logic [DATA_W-1:0] half_cyc;
    logic [3:0] bank;
    logic [1:0] widx;
    logic banked;
    logic wr_ctrl;
    logic ack;
    logic edge_seen;
    logic wd_tick;

    function automatic logic [DATA_W-1:0] word_of(
        input logic [NUM_LINES-1:0] vec,
        input logic [1:0] idx
    );
        word_of = vec[idx * DATA_W +: DATA_W];
    endfunction : word_of

    function automatic logic [NUM_LINES-1:0] put_word(
        input logic [NUM_LINES-1:0] vec,
        input logic [1:0] idx,
        input logic [DATA_W-1:0] data
    );
        logic [NUM_LINES-1:0] res;
        res = vec;
        res[idx * DATA_W +: DATA_W] = data;
        put_word = res;
    endfunction : put_word

    dfw_filter u_filter (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(pin_i),
        .filt_en_i(q.filt_en),
        .filt_tick_i(q.ftick),
        .level_o(level)
    );

    always_comb begin
        next_q = q;
        bank = bus_i.addr[5:2];
        widx = bus_i.addr[1:0];
        banked = (bank <= BANK_LAST) && (widx < 2'(NUM_WORDS));
        wr_ctrl = bus_i.wr && (bus_i.addr == ADDR_CTRL);
        ack = wr_ctrl && bus_i.wdata[CTRL_ACK];

        // filter clock period is half the chosen interval
        if (ALT_VARIANT) begin
            if (q.fdiv[1:0] == SEL_FAST) begin
                half_cyc = HALF_FAST;
            end else if (q.fdiv[1:0] == SEL_MID) begin
                half_cyc = HALF_MID;
            end else begin
                half_cyc = HALF_LONG;
            end
        end else if (q.fdiv < HALF_MIN) begin
            half_cyc = HALF_MIN;
        end else if (q.fdiv > HALF_MAX) begin
            half_cyc = HALF_MAX;
        end else begin
            half_cyc = q.fdiv;
        end
        if (q.fcnt >= half_cyc - 32'h1) begin
            next_q.fcnt = '0;
            next_q.ftick = 1'b1;
        end else begin
            next_q.fcnt = q.fcnt + 32'h1;
            next_q.ftick = 1'b0;
        end

        // edges seen on conditioned levels only
        next_q.prev_level = level;
        rise = level & ~q.prev_level & q.rise_en;
        fall = ~level & q.prev_level & q.fall_en;
        edge_seen = |(rise | fall);
        // one flag for all lines; the host reads the levels itself
        next_q.chg = edge_seen | (q.chg & ~ack);
        next_q.ovf = (edge_seen & q.chg & ~ack) | (q.ovf & ~ack);
        next_q.cd_seen = edge_seen | q.cd_seen;

        // watchdog tick prescaler
        wd_tick = (q.wd_tcnt == WD_TICK_LAST);
        next_q.wd_tcnt = wd_tick ? 8'h0 : q.wd_tcnt + 8'h1;
        if (wr_ctrl) begin
            if (!bus_i.wdata[CTRL_ARM]) begin
                next_q.armed = 1'b0;
                next_q.expired = 1'b0;
            end else if (!q.armed) begin
                next_q.armed = 1'b1;
                next_q.wd_cnt = q.wd_timeout;
            end
            if (bus_i.wdata[CTRL_KICK] && q.armed && !q.expired) begin
                next_q.wd_cnt = q.wd_timeout;
            end
        end else if (q.armed && !q.expired && wd_tick) begin
            if (q.wd_cnt == '0) begin
                next_q.expired = 1'b1;
                next_q.safe_hold = 1'b1;
            end else begin
                next_q.wd_cnt = q.wd_cnt - 32'h1;
            end
        end

        // register writes
        if (bus_i.wr && banked) begin
            if (bank == BANK_DIR) begin
                if (!q.expired) begin
                    next_q.dir = put_word(q.dir, widx, bus_i.wdata);
                end
            end else if (bank == BANK_OUT) begin
                if (!q.expired) begin
                    next_q.out = put_word(q.out, widx, bus_i.wdata);
                    // a fresh value after disarm releases the safe states
                    next_q.safe_hold = 1'b0;
                end
            end else if (bank == BANK_FEN) begin
                next_q.filt_en = put_word(q.filt_en, widx, bus_i.wdata);
            end else if (bank == BANK_RISE) begin
                next_q.rise_en = put_word(q.rise_en, widx, bus_i.wdata);
                next_q.cd_seen = edge_seen;
            end else if (bank == BANK_FALL) begin
                next_q.fall_en = put_word(q.fall_en, widx, bus_i.wdata);
                next_q.cd_seen = edge_seen;
            end else if (bank == BANK_SEN) begin
                next_q.safe_en = put_word(q.safe_en, widx, bus_i.wdata);
            end else if (bank == BANK_SVAL) begin
                next_q.safe_val = put_word(q.safe_val, widx, bus_i.wdata);
            end
        end else if (bus_i.wr && bus_i.addr == ADDR_FDIV) begin
            next_q.fdiv = bus_i.wdata;
        end else if (bus_i.wr && bus_i.addr == ADDR_WDTO) begin
            next_q.wd_timeout = bus_i.wdata;
        end

        // power-up states land once the settling time has run
        if (!q.pu_done) begin
            if (q.pu_cnt == PU_LAST) begin
                next_q.pu_done = 1'b1;
                next_q.dir = pwrup_dir_i;
                next_q.out = pwrup_val_i;
            end else begin
                next_q.pu_cnt = q.pu_cnt + 32'h1;
            end
        end

        // change-watched lines stay hidden until an interrupt has fired
        read_mask = ~((q.rise_en | q.fall_en) & {NUM_LINES{~q.cd_seen}});
        next_q.rdata = '0;
        if (bus_i.rd && banked) begin
            if (bank == BANK_DIR) begin
                next_q.rdata = word_of(q.dir, widx);
            end else if (bank == BANK_OUT) begin
                next_q.rdata = word_of(q.out, widx);
            end else if (bank == BANK_IN) begin
                next_q.rdata = word_of(level & read_mask, widx);
            end else if (bank == BANK_FEN) begin
                next_q.rdata = word_of(q.filt_en, widx);
            end else if (bank == BANK_RISE) begin
                next_q.rdata = word_of(q.rise_en, widx);
            end else if (bank == BANK_FALL) begin
                next_q.rdata = word_of(q.fall_en, widx);
            end else if (bank == BANK_SEN) begin
                next_q.rdata = word_of(q.safe_en, widx);
            end else begin
                next_q.rdata = word_of(q.safe_val, widx);
            end
        end else if (bus_i.rd && bus_i.addr == ADDR_FDIV) begin
            next_q.rdata = q.fdiv;
        end else if (bus_i.rd && bus_i.addr == ADDR_WDTO) begin
            next_q.rdata = q.wd_timeout;
        end else if (bus_i.rd && bus_i.addr == ADDR_CTRL) begin
            next_q.rdata[CTRL_ARM] = q.armed;
        end else if (bus_i.rd && bus_i.addr == ADDR_STAT) begin
            next_q.rdata[STAT_CHG] = q.chg;
            next_q.rdata[STAT_OVF] = q.ovf;
            next_q.rdata[STAT_WDX] = q.expired;
            next_q.rdata[STAT_ARM] = q.armed;
            next_q.rdata[STAT_PU] = q.pu_done;
        end

        // safe states override; the alternative part leaves input lines floating
        if (!q.safe_hold) begin
            force_mask = '0;
        end else if (ALT_VARIANT) begin
            force_mask = q.safe_en & q.dir;
        end else begin
            force_mask = q.safe_en;
        end
        next_q.pin = (q.out & ~force_mask) | (q.safe_val & force_mask);
        // all lines stay inputs until power-up states are applied
        next_q.pin_oe = q.pu_done ? (q.dir | force_mask) : '0;
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            q <= '0;
            q.fdiv <= FDIV_RESET;
            q.wd_timeout <= WDTO_RESET;
        end else begin
            q <= next_q;
        end
    end

    assign rdata_o = q.rdata;
    assign pin_o = q.pin;
    assign pin_oe_o = q.pin_oe;
    assign change_irq_o = q.chg;
    assign wd_expired_o = q.expired;

endmodule : dfw_top

/* File: src/dfw_pkg.sv */
// shared constants and carrier types for the line filter, change and watchdog block
// assumes a single 200 MHz clock and a plain word-addressed register port
package dfw_pkg;

    localparam int NUM_LINES = 96;
    localparam int NUM_WORDS = 3;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;

    // timing
    localparam int CLK_PS = 5000;
    localparam longint FILT_MIN_NS = 400;
    localparam longint FILT_MAX_NS = 200000000;
    localparam longint ALT_FAST_NS = 160;
    localparam longint ALT_MID_NS = 10240;
    localparam longint ALT_SLOW_NS = 5120000;
    localparam longint WD_TICK_NS = 100;
    localparam longint WD_TICK_ALT_NS = 32;
    localparam longint PWRUP_MS = 400;
    localparam longint PWRUP_ALT_MS = 500;

    // half interval in clock cycles, least times rounded up
    localparam int FILT_HALF_MIN = int'((FILT_MIN_NS * 1000 / 2 + CLK_PS - 1) / CLK_PS);
    localparam int FILT_HALF_MAX = int'((FILT_MAX_NS * 1000 / 2 + CLK_PS - 1) / CLK_PS);
    localparam int ALT_HALF_FAST = int'((ALT_FAST_NS * 1000 / 2 + CLK_PS - 1) / CLK_PS);
    localparam int ALT_HALF_MID = int'((ALT_MID_NS * 1000 / 2 + CLK_PS - 1) / CLK_PS);
    localparam int ALT_HALF_SLOW = int'((ALT_SLOW_NS * 1000 / 2 + CLK_PS - 1) / CLK_PS);
    // tick periods rounded down
    localparam int WD_TICK_CYC = int'(WD_TICK_NS * 1000 / CLK_PS);
    localparam int WD_TICK_ALT_CYC = int'(WD_TICK_ALT_NS * 1000 / CLK_PS);
    localparam int PWRUP_CYC = int'(PWRUP_MS * 1000000000 / CLK_PS);
    localparam int PWRUP_ALT_CYC = int'(PWRUP_ALT_MS * 1000000000 / CLK_PS);

    // banked registers: addr[5:2] picks the bank, addr[1:0] the word
    localparam logic [3:0] BANK_DIR = 4'h0;
    localparam logic [3:0] BANK_OUT = 4'h1;
    localparam logic [3:0] BANK_IN = 4'h2;
    localparam logic [3:0] BANK_FEN = 4'h3;
    localparam logic [3:0] BANK_RISE = 4'h4;
    localparam logic [3:0] BANK_FALL = 4'h5;
    localparam logic [3:0] BANK_SEN = 4'h6;
    localparam logic [3:0] BANK_SVAL = 4'h7;
    localparam logic [3:0] BANK_LAST = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_FDIV = 6'h20;
    localparam logic [ADDR_W-1:0] ADDR_WDTO = 6'h21;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 6'h22;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 6'h23;

    // control and status bits
    localparam int CTRL_ARM = 0;
    localparam int CTRL_KICK = 1;
    localparam int CTRL_ACK = 2;
    localparam int STAT_CHG = 0;
    localparam int STAT_OVF = 1;
    localparam int STAT_WDX = 2;
    localparam int STAT_ARM = 3;
    localparam int STAT_PU = 4;

    localparam logic [DATA_W-1:0] FDIV_RESET = DATA_W'(FILT_HALF_MIN);
    localparam logic [DATA_W-1:0] WDTO_RESET = 32'hffffffff;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } dfw_bus_req_s;

endpackage : dfw_pkg

/* File: src/dfw_filter.sv */
// per-line input synchroniser and glitch filter
// assumes filt_tick_i is a one-cycle pulse once per half filter interval
`timescale 1ns/1ps
module dfw_filter (
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // raw pins and control
    input wire logic [dfw_pkg::NUM_LINES-1:0] pin_i,
    input wire logic [dfw_pkg::NUM_LINES-1:0] filt_en_i,
    input wire logic filt_tick_i,
    // conditioned levels
    output logic [dfw_pkg::NUM_LINES-1:0] level_o
);
    import dfw_pkg::*;

    typedef struct packed {
        logic [NUM_LINES-1:0] s1;
        logic [NUM_LINES-1:0] s2;
        logic [NUM_LINES-1:0] s3;
        logic [NUM_LINES-1:0] clean;
        logic [NUM_LINES-1:0] moved;
        logic [NUM_LINES-1:0] filt;
        logic [NUM_LINES-1:0] level;
    } dfw_filt_state_s;

    dfw_filt_state_s q;
    dfw_filt_state_s next_q;
    logic [NUM_LINES-1:0] moved_now;

    always_comb begin
        next_q = q;
        next_q.s1 = pin_i;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        // accept a raw change only once the last two stages agree on every line at once
        next_q.clean = (q.s2 == q.s3) ? q.s3 : q.clean;
        moved_now = q.moved | (next_q.clean ^ q.clean);
        if (filt_tick_i) begin
            // a line that held still for a whole tick period takes its new level
            next_q.filt = (q.filt & moved_now) | (q.clean & ~moved_now);
            next_q.moved = '0;
        end else begin
            next_q.moved = moved_now;
        end
        // same path for both edge directions
        next_q.level = (filt_en_i & next_q.filt) | (~filt_en_i & next_q.clean);
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign level_o = q.level;

endmodule : dfw_filter

/* File: dv/dfw_top_sva.sv */
// port-level assertions for the line filter, change and watchdog block
// assumes the single clock domain and synchronous reset of dfw_top
`timescale 1ns/1ps
module dfw_top_sva
    import dfw_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // register port
    input wire dfw_pkg::dfw_bus_req_s bus_i,
    input wire logic [dfw_pkg::DATA_W-1:0] rdata_o,
    // lines
    input wire logic [dfw_pkg::NUM_LINES-1:0] pin_i,
    input wire logic [dfw_pkg::NUM_LINES-1:0] pin_o,
    input wire logic [dfw_pkg::NUM_LINES-1:0] pin_oe_o,
    input wire logic [dfw_pkg::NUM_LINES-1:0] pwrup_dir_i,
    // events
    input wire logic change_irq_o,
    input wire logic wd_expired_o
);
    logic [NUM_LINES-1:0] pin_q;
    logic [9:0] since_pin, since_ack, since_dis, since_wr, since_rst;
    logic ctrl_wr;

    // saturating so long quiet spells never wrap back to small values
    function automatic logic [9:0] up(input logic [9:0] v);
        return (v == 10'h3ff) ? v : v + 10'h1;
    endfunction : up

    assign ctrl_wr = bus_i.wr && bus_i.addr == ADDR_CTRL;

    always_ff @(posedge clock_i) begin
        pin_q <= pin_i;
        since_pin <= (sys_rst_i || pin_i != pin_q) ? 10'h0 : up(since_pin);
        since_ack <= (sys_rst_i || (ctrl_wr && bus_i.wdata[CTRL_ACK])) ? 10'h0 : up(since_ack);
        since_dis <= (sys_rst_i || (ctrl_wr && !bus_i.wdata[CTRL_ARM])) ? 10'h0 : up(since_dis);
        since_wr <= (sys_rst_i || bus_i.wr) ? 10'h0 : up(since_wr);
        since_rst <= sys_rst_i ? 10'h0 : up(since_rst);
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    rdata_idle_a: assert property (
        !$past(bus_i.rd) |-> rdata_o == '0) else $error("read data outside read slot");
    reset_quiet_a: assert property (disable iff (1'b0)
        sys_rst_i ##1 sys_rst_i |-> pin_oe_o == '0 && !change_irq_o && !wd_expired_o)
        else $error("outputs active in reset");
    pwrup_dir_a: assert property (
        since_rst == 10'd30 && since_wr == 10'd30 |-> pin_oe_o == pwrup_dir_i)
        else $error("power-up direction not applied");
    irq_cause_a: assert property (
        $rose(change_irq_o) |-> since_pin <= 10'd400) else $error("change flag without line edge");
    irq_clear_a: assert property (
        $fell(change_irq_o) |-> since_ack <= 10'd3) else $error("change flag dropped without ack");
    exp_release_a: assert property (
        $fell(wd_expired_o) |-> since_dis <= 10'd3) else $error("expiry dropped without disarm");
    // a disarm taken on this edge legally drops the flag on the next
    exp_sticky_a: assert property (
        wd_expired_o && since_dis > 10'd4 && !(ctrl_wr && !bus_i.wdata[CTRL_ARM])
        |=> wd_expired_o) else $error("expiry not held");
    safe_stable_a: assert property (
        wd_expired_o && $past(wd_expired_o, 3) && since_wr > 10'd4
        |-> $stable(pin_o) && $stable(pin_oe_o)) else $error("outputs moved while expired");
endmodule : dfw_top_sva

bind dfw_top dfw_top_sva u_dfw_top_sva (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .bus_i(bus_i),
    .rdata_o(rdata_o),
    .pin_i(pin_i),
    .pin_o(pin_o),
    .pin_oe_o(pin_oe_o),
    .pwrup_dir_i(pwrup_dir_i),
    .change_irq_o(change_irq_o),
    .wd_expired_o(wd_expired_o)
);

/* File: dv/dfw_field_model.sv */
// field side of the line bank: resolves each line from block drive and outside source
// assumes outside sources never fight a line that the block drives
`timescale 1ns/1ps
module dfw_field_model
    import dfw_pkg::*;
(
    // from the block
    input wire logic [dfw_pkg::NUM_LINES-1:0] drive_i,
    input wire logic [dfw_pkg::NUM_LINES-1:0] drive_en_i,
    // outside sources
    input wire logic [dfw_pkg::NUM_LINES-1:0] ext_i,
    // resolved lines
    output logic [dfw_pkg::NUM_LINES-1:0] line_o
);
    // a driven line reads back its own level, as on the real pin
    assign line_o = (drive_en_i & drive_i) | (~drive_en_i & ext_i);
endmodule : dfw_field_model

/* File: dv/tb_dfw_top.sv */
// self-checking bench for dfw_top: filter, change, power-up and watchdog
// assumes shortened power-up and filter limits via parameters
`timescale 1ns/1ps
module tb_dfw_top;
    import dfw_pkg::*;
    localparam logic [NUM_LINES-1:0] PU_DIR = 96'h0000_0000_0000_00ff_0000_0000;
    localparam logic [NUM_LINES-1:0] PU_VAL = 96'h0000_0000_0000_000f_0000_0000;
    logic clock_i, sys_rst_i, change_irq_o, wd_expired_o;
    dfw_bus_req_s bus_i;
    logic [DATA_W-1:0] rdata_o;
    logic [NUM_LINES-1:0] pin_i, pin_o, pin_oe_o, ext;
    int error_cnt = 0;
    int compares = 0;
    int n;

    dfw_top #(.PWRUP_CYCLES(20), .FILT_HALF_LIMIT(64), .ALT_HALF_LONG(64)) u_dfw_top (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pwrup_dir_i(PU_DIR),
        .pwrup_val_i(PU_VAL), .change_irq_o(change_irq_o), .wd_expired_o(wd_expired_o));
    dfw_field_model u_dfw_field_model (
        .drive_i(pin_o), .drive_en_i(pin_oe_o), .ext_i(ext), .line_o(pin_i));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic cyc(input int c);
        repeat (c) @(posedge clock_i);
    endtask : cyc
    task automatic put(input int i, input logic v);
        @(posedge clock_i);
        ext[i] <= v;
    endtask : put
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clock_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i);
        bus_i <= '0;
    endtask : wr
    // read data are only valid in the cycle after the strobe
    task automatic rd(input string nm, input logic [5:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        @(posedge clock_i);
        bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock_i);
        bus_i <= '0;
        #1;
        chk(nm, e, rdata_o & m);
    endtask : rd
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    initial begin
        sys_rst_i = 1'b1;
        bus_i = '0;
        ext = 96'h4;
        cyc(3);
        sys_rst_i <= 1'b0;
        cyc(40);
        chk("pu_oe", 32'hff, pin_oe_o[63:32]);
        chk("pu_val", 32'hf, pin_o[63:32] & pin_oe_o[63:32]);
        rd("pu_done", ADDR_STAT, 32'h10, 32'h10);
        rd("dir1", 6'h01, 32'hffffffff, 32'hff);
        rd("fdiv", ADDR_FDIV, 32'hffffffff, FDIV_RESET);
        rd("wdto", ADDR_WDTO, 32'hffffffff, WDTO_RESET);
        rd("unmapped", 6'h30, 32'hffffffff, 32'h0);
        $display("test power-up done");
        // filter on line 0 at the shortest half interval, line 1 raw
        wr(6'h0c, 32'h1);
        put(0, 1'b1); cyc(30); put(0, 1'b0); cyc(200);
        rd("glitch_hi", 6'h08, 32'h1, 32'h0);
        put(0, 1'b1); cyc(130);
        rd("pass_hi", 6'h08, 32'h1, 32'h1);
        put(0, 1'b0); cyc(30); put(0, 1'b1); cyc(200);
        rd("glitch_lo", 6'h08, 32'h1, 32'h1);
        put(0, 1'b0); cyc(130);
        rd("pass_lo", 6'h08, 32'h1, 32'h0);
        put(1, 1'b1); cyc(10);
        rd("raw_line", 6'h08, 32'h2, 32'h2);
        $display("test filter done");
        // line 2 rising only, line 3 falling only
        wr(6'h10, 32'h4);
        wr(6'h14, 32'h8);
        rd("hidden", 6'h08, 32'hc, 32'h0);
        put(2, 1'b0); put(3, 1'b1); cyc(20);
        chk("no_irq", 32'h0, {31'h0, change_irq_o});
        put(2, 1'b1); cyc(20);
        chk("irq", 32'h1, {31'h0, change_irq_o});
        rd("shown", 6'h08, 32'hc, 32'hc);
        rd("no_ovf", ADDR_STAT, 32'h3, 32'h1);
        put(3, 1'b0); cyc(20);
        rd("ovf", ADDR_STAT, 32'h3, 32'h3);
        wr(ADDR_CTRL, 32'h4); cyc(4);
        chk("irq_ack", 32'h0, {31'h0, change_irq_o});
        rd("ack_stat", ADDR_STAT, 32'h3, 32'h0);
        wr(6'h10, 32'h5);
        put(0, 1'b1); cyc(30); put(0, 1'b0); cyc(150);
        chk("glitch_irq", 32'h0, {31'h0, change_irq_o});
        $display("test change done");
        wr(6'h00, 32'hffff0000);
        wr(6'h04, 32'h00ab0000);
        wr(6'h18, 32'h00ffff00);
        wr(6'h1c, 32'h005a3c00);
        wr(ADDR_WDTO, 32'h3); cyc(4);
        chk("out", 32'h00ab, {16'h0, pin_o[31:16]});
        wr(ADDR_CTRL, 32'h1);
        repeat (4) begin
            cyc(36); wr(ADDR_CTRL, 32'h3);
        end
        chk("kicked", 32'h0, {31'h0, wd_expired_o});
        for (n = 0; n < 300 && wd_expired_o !== 1'b1; n++) @(posedge clock_i);
        if (n == 300) begin
            error_cnt++;
            $display("CHECK FAILED expiry expected 1 seen %b", wd_expired_o);
            conclude();
        end
        chk("exp_time", 32'h1, {31'h0, n >= 55 && n <= 100});
        cyc(3);
        chk("safe_val", 32'h5a3c, {16'h0, pin_o[23:8]});
        chk("safe_oe", 32'hffffff, {8'h0, pin_oe_o[31:8]});
        wr(6'h04, 32'hffff0000);
        wr(6'h00, 32'h0); cyc(100);
        chk("out_ign", 32'h005a, {16'h0, pin_o[31:16]});
        chk("dir_ign", 32'hffff, {16'h0, pin_oe_o[31:16]});
        rd("exp_stat", ADDR_STAT, 32'h4, 32'h4);
        wr(ADDR_CTRL, 32'h0); cyc(4);
        chk("disarm", 32'h0, {31'h0, wd_expired_o});
        chk("safe_hold", 32'h5a3c, {16'h0, pin_o[23:8]});
        wr(6'h04, 32'h12340000); cyc(4);
        chk("new_out", 32'h1234, {16'h0, pin_o[31:16]});
        chk("release_oe", 32'h0, {24'h0, pin_oe_o[15:8]});
        $display("test watchdog done");
        conclude();
    end
endmodule : tb_dfw_top
